// ---- design/pmp_pkg.sv ----
// Shared constants and types of the program message parser.
// Assumes bytes arrive already handshaken, on the core clock.
package pmp_pkg;

	// Special characters of a message and the letter case gap
	localparam logic [7:0] CH_NL = 8'h0A;
	localparam logic [7:0] CH_SP = 8'h20;
	localparam logic [7:0] CH_STAR = 8'h2A;
	localparam logic [7:0] CH_COMMA = 8'h2C;
	localparam logic [7:0] CH_COLON = 8'h3A;
	localparam logic [7:0] CH_SEMI = 8'h3B;
	localparam logic [7:0] CH_QUERY = 8'h3F;
	localparam logic [7:0] CASE_GAP = 8'h20;

	// Values after reset
	localparam logic [4:0] BUS_ADDR_RST = 5'h14;
	localparam logic [15:0] ENABLE_RST = 16'h0000;
	localparam logic [31:0] TOK_BLANK = 32'h20202020;

	// Mnemonic tokens, first four letters, space padded
	localparam logic [31:0] TK_STAT = 32'h53544154;
	localparam logic [31:0] TK_OPER = 32'h4F504552;
	localparam logic [31:0] TK_QUES = 32'h51554553;
	localparam logic [31:0] TK_ENAB = 32'h454E4142;
	localparam logic [31:0] TK_SCAN = 32'h5343414E;
	localparam logic [31:0] TK_RATE = 32'h52415445;
	localparam logic [31:0] TK_TIME = 32'h54494D45;
	localparam logic [31:0] TK_PADD = 32'h50414444;
	localparam logic [31:0] TK_POS = 32'h504F5320;
	localparam logic [31:0] TK_POSI = 32'h504F5349;
	localparam logic [31:0] TK_INIT = 32'h494E4954;
	localparam logic [31:0] TK_ABOR = 32'h41424F52;
	localparam logic [31:0] TK_CLS = 32'h434C5320;
	localparam logic [31:0] TK_RST = 32'h52535420;

	typedef enum logic [3:0] {
		OP_NONE, OP_CLS, OP_RST, OP_INIT, OP_ABORT, OP_SCAN_RATE,
		OP_SCAN_TIMER, OP_PADD_POS, OP_OPER_ENAB, OP_QUES_ENAB
	} op_t;
	typedef enum logic [1:0] {SUB_ROOT, SUB_SCAN, SUB_STAT, SUB_PADD} sub_t;
	typedef enum logic [1:0] {NODE_NONE, NODE_OPER, NODE_QUES} node_t;
	typedef enum logic [2:0] {
		ST_HDR, ST_STAR, ST_MNEM, ST_QMARK, ST_SEP, ST_DATA, ST_DISCARD, ST_EXEC
	} pstate_t;

	// One decoded instruction awaiting the terminator
	typedef struct packed {
		op_t op;
		logic query;
		logic [3:0] idx;
		logic [15:0] val;
		logic [3:0] pcnt;
	} inst_t;

endpackage

// ---- design/program_message_parser.sv ----
// Program message parser with its input byte FIFO.
// Assumes bytes, end flag and clears come from logic on core_clk_i.
//
// How it works
// - The bus address output starts at 20 after reset until loaded anew.
// - A header is mnemonics joined by colons, naming one operation.
// - A trailing question mark makes the header a query, else a command.
// - One or more spaces separate a header from its data.
// - A header without data may be followed at once by terminator or semicolon.
// - Parameters split at commas, spaces around commas ignored.
// - A lone mnemonic before the terminator is a complete instruction.
// - In a compound header the first mnemonic is the subsystem, the last the function.
// - A common header is an asterisk directly followed by the name, nothing between.
// - After a semicolon without colon the current subsystem stays selected.
// - The same function mnemonic acts on the register its selector names.
// - Writing a status enable loads its decimal value as a bit mask.
// - A message ends with a newline, the end flag on its last byte, or both.
// - Instructions are held and executed only after the terminator.
// - Mnemonics match regardless of letter case.
// - A colon right after a semicolon returns to the root level.
`timescale 1ns/1ps

module pmp_byte_fifo
	import pmp_pkg::*;
#(
	parameter int WIDTH = 9,
	parameter int DEPTH = 8
)
(
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	input wire logic in_valid_i,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic in_ready_o,
	output logic out_valid_o,
	output logic [WIDTH-1:0] out_data_o,
	input wire logic out_ready_i
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wr;
		logic [AW-1:0] rd;
		logic [AW:0] cnt;
		logic room;
	} fifo_state_t;

	fifo_state_t s;
	fifo_state_t next_s;
	logic push;
	logic pop;

	// Pointer wrap, counts and a registered ready flag
	always_comb
	begin
		next_s = s;
		push = in_valid_i && s.room;
		pop = (s.cnt != '0) && out_ready_i;
		if (push)
		begin
			next_s.mem[s.wr] = in_data_i;
			next_s.wr = (s.wr == AW'(DEPTH - 1)) ? '0 : s.wr + 1'b1;
		end
		if (pop)
			next_s.rd = (s.rd == AW'(DEPTH - 1)) ? '0 : s.rd + 1'b1;
		if (push && !pop)
			next_s.cnt = s.cnt + 1'b1;
		else if (pop && !push)
			next_s.cnt = s.cnt - 1'b1;
		next_s.room = (next_s.cnt != (AW + 1)'(DEPTH));
	end

	always_ff @(posedge core_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			s <= '0;
			// Ready stands high through reset, the FIFO is empty
			s.room <= 1'b1;
		end
		else
			s <= next_s;
	end

	assign in_ready_o = s.room;
	assign out_valid_o = (s.cnt != '0);
	assign out_data_o = s.mem[s.rd];
endmodule

module program_message_parser
	import pmp_pkg::*;
#(
	parameter int FIFO_DEPTH = 8,
	parameter int QDEPTH = 4
)
(
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	input wire logic [7:0] byte_i,
	input wire logic byte_valid_i,
	input wire logic eoi_i,
	output logic byte_ready_o,
	input wire logic dev_clear_i,
	input wire logic err_clear_i,
	input wire logic addr_we_i,
	input wire logic [4:0] addr_i,
	output logic [4:0] bus_address_o,
	output logic exec_valid_o,
	output op_t exec_op_o,
	output logic exec_query_o,
	output logic [3:0] exec_index_o,
	output logic [15:0] exec_value_o,
	output logic [3:0] exec_params_o,
	output logic [15:0] oper_enable_o,
	output logic [15:0] ques_enable_o,
	output logic syntax_error_o
);
	localparam int QAW = $clog2(QDEPTH);

	typedef struct packed {
		pstate_t st;
		logic pend;
		logic [0:3][7:0] tok;
		logic [2:0] nchr;
		logic [3:0] suf;
		logic common;
		logic query;
		sub_t sub;
		node_t node;
		logic [3:0] idx;
		op_t op;
		logic [15:0] val;
		logic [3:0] pcnt;
		logic [QDEPTH-1:0][$bits(inst_t)-1:0] q;
		logic [QAW:0] qn;
		logic [QAW-1:0] qr;
		logic exec_valid;
		inst_t exec;
		logic [15:0] oper_en;
		logic [15:0] ques_en;
		logic [4:0] bus_addr;
		logic syn_err;
	} parser_state_t;

	parser_state_t s;
	parser_state_t next_s;
	logic fifo_valid;
	logic [8:0] fifo_data;
	logic pop;
	logic err;
	logic commit;
	logic term;
	logic [7:0] ch;
	logic [7:0] up;
	logic letter;
	logic digit;
	inst_t head;

	// Bytes wait here while an earlier message executes
	pmp_byte_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) u_fifo (
		.core_clk_i(core_clk_i),
		.reset_n_i(reset_n_i),
		.in_valid_i(byte_valid_i),
		.in_data_i({eoi_i, byte_i}),
		.in_ready_o(byte_ready_o),
		.out_valid_o(fifo_valid),
		.out_data_o(fifo_data),
		.out_ready_i(pop)
	);

	// Final header to operation; selectors route shared names
	function automatic op_t resolve(sub_t sub, node_t node, logic [31:0] tok, logic common);
		op_t op;
		op = OP_NONE;
		if (common)
		begin
			if (tok == TK_CLS)
				op = OP_CLS;
			else if (tok == TK_RST)
				op = OP_RST;
		end
		else
		begin
			case (sub)
				SUB_ROOT:
					if (tok == TK_INIT)
						op = OP_INIT;
					else if (tok == TK_ABOR)
						op = OP_ABORT;
				SUB_SCAN:
					if (tok == TK_RATE)
						op = OP_SCAN_RATE;
					else if (tok == TK_TIME)
						op = OP_SCAN_TIMER;
				SUB_PADD:
					if (tok == TK_POS || tok == TK_POSI)
						op = OP_PADD_POS;
				SUB_STAT:
					if (tok == TK_ENAB && node == NODE_OPER)
						op = OP_OPER_ENAB;
					else if (tok == TK_ENAB && node == NODE_QUES)
						op = OP_QUES_ENAB;
				default:
					op = OP_NONE;
			endcase
		end
		return op;
	endfunction

	// Character classes; lower case folds to upper
	always_comb
	begin
		ch = s.pend ? CH_NL : fifo_data[7:0];
		up = (ch >= 8'h61 && ch <= 8'h7A) ? ch - CASE_GAP : ch;
		letter = (up >= 8'h41 && up <= 8'h5A);
		digit = (ch >= 8'h30 && ch <= 8'h39);
		head = inst_t'(s.q[s.qr]);
	end

	// Parsing, queueing and execution
	always_comb
	begin
		next_s = s;
		next_s.exec_valid = 1'b0;
		pop = 1'b0;
		err = 1'b0;
		commit = 1'b0;
		term = 1'b0;
		if (addr_we_i)
			next_s.bus_addr = addr_i;
		if (s.st == ST_EXEC)
		begin
			next_s.exec_valid = 1'b1;
			next_s.exec = head;
			if (!head.query && head.op == OP_OPER_ENAB)
				next_s.oper_en = head.val;
			if (!head.query && head.op == OP_QUES_ENAB)
				next_s.ques_en = head.val;
			if ({1'b0, s.qr} == s.qn - 1'b1)
			begin
				next_s.qn = '0;
				next_s.qr = '0;
				next_s.st = ST_HDR;
			end
			else
				next_s.qr = s.qr + 1'b1;
		end
		else if (s.pend || fifo_valid)
		begin
			pop = !s.pend;
			// end flag on a plain byte acts as a newline after it
			next_s.pend = !s.pend && fifo_data[8] && fifo_data[7:0] != CH_NL;
			term = (ch == CH_NL);
			case (s.st)
				ST_HDR:
					if (ch == CH_COLON)
					begin
						next_s.sub = SUB_ROOT;
						next_s.node = NODE_NONE;
						next_s.st = ST_MNEM;
					end
					else if (ch == CH_STAR)
						next_s.st = ST_STAR;
					// subsystem kept after a bare semicolon
					else if (letter)
					begin
						next_s.tok[0] = up;
						next_s.nchr = 3'd1;
						next_s.st = ST_MNEM;
					end
					else if (!term)
						err = 1'b1;
				ST_STAR:
					// name must follow the asterisk at once
					if (letter)
					begin
						next_s.common = 1'b1;
						next_s.tok[0] = up;
						next_s.nchr = 3'd1;
						next_s.st = ST_MNEM;
					end
					else
						err = 1'b1;
				ST_MNEM:
					if (letter)
					begin
						// Long forms compare on their first four letters
						if (s.nchr < 3'd4)
						begin
							next_s.tok[s.nchr[1:0]] = up;
							next_s.nchr = s.nchr + 1'b1;
						end
					end
					else if (s.nchr == '0)
						err = 1'b1;
					else if (digit)
						next_s.suf = ch[3:0];
					else if (ch == CH_COLON)
					begin
						next_s.tok = TOK_BLANK;
						next_s.nchr = '0;
						next_s.suf = '0;
						if (s.common)
							err = 1'b1;
						else if (s.sub == SUB_ROOT && s.tok == TK_STAT)
							next_s.sub = SUB_STAT;
						else if (s.sub == SUB_ROOT && s.tok == TK_SCAN)
							next_s.sub = SUB_SCAN;
						else if (s.sub == SUB_ROOT && s.tok == TK_PADD)
						begin
							next_s.sub = SUB_PADD;
							next_s.idx = s.suf;
						end
						else if (s.sub == SUB_STAT && s.tok == TK_OPER)
							next_s.node = NODE_OPER;
						else if (s.sub == SUB_STAT && s.tok == TK_QUES)
							next_s.node = NODE_QUES;
						else
							err = 1'b1;
					end
					else if (ch == CH_QUERY || ch == CH_SP || ch == CH_SEMI || term)
					begin
						next_s.op = resolve(s.sub, s.node, s.tok, s.common);
						err = (next_s.op == OP_NONE);
						if (ch == CH_QUERY)
						begin
							next_s.query = 1'b1;
							next_s.st = ST_QMARK;
						end
						else if (ch == CH_SP)
							next_s.st = ST_SEP;
						else
							commit = 1'b1;
					end
					else
						err = 1'b1;
				ST_QMARK:
					if (ch == CH_SP)
						next_s.st = ST_SEP;
					else if (ch == CH_SEMI || term)
						commit = 1'b1;
					else
						err = 1'b1;
				ST_SEP:
					if (ch == CH_SEMI || term)
						commit = 1'b1;
					else if (ch == CH_COMMA)
						err = 1'b1;
					else if (ch != CH_SP)
					begin
						next_s.st = ST_DATA;
						next_s.pcnt = 4'd1;
						if (digit)
							next_s.val = {12'h000, ch[3:0]};
					end
				ST_DATA:
					if (ch == CH_SEMI || term)
						commit = 1'b1;
					else if (ch == CH_COMMA)
						next_s.pcnt = s.pcnt + 1'b1;
					else if (digit && s.pcnt == 4'd1)
						next_s.val = 16'(s.val * 16'd10 + {12'h000, ch[3:0]});
				ST_DISCARD:
					next_s.st = ST_DISCARD;
				default:
					err = 1'b1;
			endcase
			// held in the queue until the terminator
			if (commit && s.qn == (QAW + 1)'(QDEPTH))
				err = 1'b1;
			else if (commit)
			begin
				next_s.q[s.qn[QAW-1:0]] = {next_s.op, next_s.query, next_s.idx, next_s.val, next_s.pcnt};
				next_s.qn = s.qn + 1'b1;
				next_s.st = ST_HDR;
			end
			if (commit || term || err)
			begin
				next_s.tok = TOK_BLANK;
				next_s.nchr = '0;
				next_s.suf = '0;
				next_s.common = 1'b0;
				next_s.query = 1'b0;
				next_s.val = '0;
				next_s.pcnt = '0;
			end
			if (err)
				next_s.st = ST_DISCARD;
			if (term)
			begin
				next_s.sub = SUB_ROOT;
				next_s.node = NODE_NONE;
				next_s.idx = '0;
				if (err || s.st == ST_DISCARD)
				begin
					next_s.qn = '0;
					next_s.st = ST_HDR;
				end
				else
					next_s.st = (next_s.qn != '0) ? ST_EXEC : ST_HDR;
			end
		end
		// Set beats clear on the error flag
		if (err_clear_i)
			next_s.syn_err = 1'b0;
		if (err)
			next_s.syn_err = 1'b1;
		// Device clear resets parsing only, not settings
		if (dev_clear_i)
		begin
			next_s.st = ST_HDR;
			next_s.pend = 1'b0;
			next_s.qn = '0;
			next_s.qr = '0;
			next_s.sub = SUB_ROOT;
			next_s.node = NODE_NONE;
			next_s.tok = TOK_BLANK;
			next_s.nchr = '0;
			// A cut paddle suffix must not reach the next message
			next_s.suf = '0;
			next_s.idx = '0;
			next_s.common = 1'b0;
			next_s.query = 1'b0;
			next_s.val = '0;
			next_s.pcnt = '0;
		end
	end

	// address comes up at its factory value
	always_ff @(posedge core_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			s <= '0;
			s.tok <= TOK_BLANK;
			s.bus_addr <= BUS_ADDR_RST;
			s.oper_en <= ENABLE_RST;
			s.ques_en <= ENABLE_RST;
		end
		else
			s <= next_s;
	end

	// Outputs straight from the state register
	assign bus_address_o = s.bus_addr;
	assign exec_valid_o = s.exec_valid;
	assign exec_op_o = s.exec.op;
	assign exec_query_o = s.exec.query;
	assign exec_index_o = s.exec.idx;
	assign exec_value_o = s.exec.val;
	assign exec_params_o = s.exec.pcnt;
	assign oper_enable_o = s.oper_en;
	assign ques_enable_o = s.ques_en;
	assign syntax_error_o = s.syn_err;
endmodule

// ---- tb/program_message_parser_props.sv ----
// Port assertions for the program message parser.
// Assumes it is bound to the parser top; one clock domain.
`timescale 1ns/1ps
module program_message_parser_props
	import pmp_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	input wire logic [7:0] byte_i,
	input wire logic byte_valid_i,
	input wire logic eoi_i,
	input wire logic byte_ready_o,
	input wire logic dev_clear_i,
	input wire logic err_clear_i,
	input wire logic addr_we_i,
	input wire logic [4:0] addr_i,
	input wire logic [4:0] bus_address_o,
	input wire logic exec_valid_o,
	input wire op_t exec_op_o,
	input wire logic exec_query_o,
	input wire logic [3:0] exec_index_o,
	input wire logic [15:0] exec_value_o,
	input wire logic [3:0] exec_params_o,
	input wire logic [15:0] oper_enable_o,
	input wire logic [15:0] ques_enable_o,
	input wire logic syntax_error_o
);
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!reset_n_i);

	// Execution steps that may touch the enables, and query steps
	sequence s_oper_wr;
		exec_valid_o && exec_op_o == OP_OPER_ENAB && !exec_query_o;
	endsequence
	sequence s_ques_wr;
		exec_valid_o && exec_op_o == OP_QUES_ENAB && !exec_query_o;
	endsequence
	sequence s_query;
		exec_valid_o && exec_query_o;
	endsequence

	chk_addr_reset: assert property ($rose(reset_n_i) |-> bus_address_o == 5'h14)
		else $error("bus address not 20 after reset");
	chk_addr_load: assert property (addr_we_i |=> bus_address_o == $past(addr_i))
		else $error("bus address not loaded");
	chk_oper_load: assert property (s_oper_wr |-> oper_enable_o == exec_value_o)
		else $error("operation enable not loaded");
	chk_ques_load: assert property (s_ques_wr |-> ques_enable_o == exec_value_o)
		else $error("questionable enable not loaded");
	// Enables move only on their own executed write
	chk_oper_hold: assert property (!$stable(oper_enable_o) |-> s_oper_wr)
		else $error("operation enable changed unasked");
	chk_ques_hold: assert property (!$stable(ques_enable_o) |-> s_ques_wr)
		else $error("questionable enable changed unasked");
	chk_query_safe: assert property (s_query |-> $stable(oper_enable_o) && $stable(ques_enable_o))
		else $error("query altered an enable");
	chk_err_sticky: assert property (syntax_error_o && !err_clear_i |=> syntax_error_o)
		else $error("error flag dropped by itself");
	chk_op_known: assert property (exec_valid_o |-> exec_op_o != OP_NONE)
		else $error("executed an empty operation");
	chk_idle_start: assert property ($rose(reset_n_i) |-> byte_ready_o && !exec_valid_o)
		else $error("not idle after reset");
endmodule

bind program_message_parser program_message_parser_props props (.core_clk_i, .reset_n_i, .byte_i,
	.byte_valid_i, .eoi_i, .byte_ready_o, .dev_clear_i, .err_clear_i, .addr_we_i, .addr_i,
	.bus_address_o, .exec_valid_o, .exec_op_o, .exec_query_o, .exec_index_o, .exec_value_o,
	.exec_params_o, .oper_enable_o, .ques_enable_o, .syntax_error_o);

// ---- tb/pmp_host_model.sv ----
// Behavioural remote controller sending message bytes.
// Assumes a byte is taken on an edge with ready high.
`timescale 1ns/1ps
module pmp_host_model
(
	input wire logic core_clk_i,
	input wire logic ready_i,
	output logic [7:0] byte_o,
	output logic valid_o,
	output logic eoi_o
);
	initial
	begin
		byte_o = 8'h00;
		valid_o = 1'b0;
		eoi_o = 1'b0;
	end

	// Holds each byte until taken; gap idles slowly between bytes
	task automatic send(input string s, input bit end_flag, input int gap);
		for (int i = 0; i < s.len(); i++)
		begin
			byte_o <= s[i];
			// end flag rides on the last byte only
			eoi_o <= end_flag && (i == s.len() - 1);
			valid_o <= 1'b1;
			@(posedge core_clk_i);
			while (ready_i !== 1'b1)
				@(posedge core_clk_i);
			if (gap > 0)
			begin
				valid_o <= 1'b0;
				byte_o <= ~s[i];
				repeat (gap) @(posedge core_clk_i);
			end
		end
		// Released bus shows inverted data, never a stale byte; a gap has already inverted it
		valid_o <= 1'b0;
		eoi_o <= 1'b0;
		if (gap == 0)
			byte_o <= ~byte_o;
	endtask
endmodule

// ---- tb/program_message_parser_tb_top.sv ----
// Self-checking bench for the program message parser.
// Assumes the host model owns the byte port; bench drives the rest.
`timescale 1ns/1ps
module program_message_parser_tb_top;
	import pmp_pkg::*;
	logic core_clk_i, reset_n_i, byte_valid, eoi, byte_ready, dev_clear, err_clear, addr_we;
	logic exec_valid, exec_query, syntax_error;
	logic [7:0] byte_d;
	logic [4:0] addr, bus_address;
	op_t exec_op;
	logic [3:0] exec_index, exec_params;
	logic [15:0] exec_value, oper_enable, ques_enable;
	logic [28:0] got[$];
	int err_count = 0;
	int num_checks = 0;

	initial
	begin
		core_clk_i = 1'b0;
		forever #5 core_clk_i = ~core_clk_i;
	end

	pmp_host_model host (.core_clk_i(core_clk_i), .ready_i(byte_ready), .byte_o(byte_d), .valid_o(byte_valid),
		.eoi_o(eoi));

	program_message_parser dut (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .byte_i(byte_d),
		.byte_valid_i(byte_valid), .eoi_i(eoi), .byte_ready_o(byte_ready), .dev_clear_i(dev_clear),
		.err_clear_i(err_clear), .addr_we_i(addr_we), .addr_i(addr), .bus_address_o(bus_address),
		.exec_valid_o(exec_valid), .exec_op_o(exec_op), .exec_query_o(exec_query), .exec_index_o(exec_index),
		.exec_value_o(exec_value), .exec_params_o(exec_params), .oper_enable_o(oper_enable),
		.ques_enable_o(ques_enable), .syntax_error_o(syntax_error));

	// Record every executed instruction in order
	always @(posedge core_clk_i)
		if (exec_valid === 1'b1)
			got.push_back({exec_op, exec_query, exec_index, exec_value, exec_params});

	task automatic check(input logic [28:0] got_v, input logic [28:0] exp_v);
		num_checks++;
		if (got_v !== exp_v)
		begin
			err_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got_v, exp_v);
		end
	endtask

	// Empty queue yields all ones, which no instruction matches
	task automatic expect_exec(input op_t op, input logic q, input logic [3:0] idx, input logic [15:0] val,
		input logic [3:0] pc);
		logic [28:0] g;
		g = (got.size() > 0) ? got.pop_front() : '1;
		check(g, {op, q, idx, val, pc});
	endtask

	task automatic msg(input string s, input bit end_flag);
		host.send(s, end_flag, 0);
		repeat (12) @(posedge core_clk_i);
	endtask

	task automatic t_reset;
		check(bus_address, 5'h14);
		check(oper_enable | ques_enable, 16'h0000);
		addr <= 5'h07;
		addr_we <= 1'b1;
		@(posedge core_clk_i);
		addr_we <= 1'b0;
		@(posedge core_clk_i);
		check(bus_address, 5'h07);
		$display("test reset done");
	endtask

	task automatic t_headers;
		msg("*CLS\n", 0);
		expect_exec(OP_CLS, 1'h0, 4'h0, 16'h0000, 4'h0);
		msg("*rst", 1);
		expect_exec(OP_RST, 1'h0, 4'h0, 16'h0000, 4'h0);
		msg("INIT;abort\n", 1);
		expect_exec(OP_INIT, 1'h0, 4'h0, 16'h0000, 4'h0);
		expect_exec(OP_ABORT, 1'h0, 4'h0, 16'h0000, 4'h0);
		msg(":PADD1:POSITION 50\n", 0);
		expect_exec(OP_PADD_POS, 1'h0, 4'h1, 16'h0032, 4'h1);
		msg(":SCAN:RATE 5;TIME?\n", 0);
		expect_exec(OP_SCAN_RATE, 1'h0, 4'h0, 16'h0005, 4'h1);
		expect_exec(OP_SCAN_TIMER, 1'h1, 4'h0, 16'h0000, 4'h0);
		msg("scan:rate   7 , 8,9\n", 0);
		expect_exec(OP_SCAN_RATE, 1'h0, 4'h0, 16'h0007, 4'h3);
		$display("test headers done");
	endtask

	task automatic t_enables;
		msg(":STAT:OPER:ENAB 15;:STAT:QUES:ENAB 16\n", 0);
		expect_exec(OP_OPER_ENAB, 1'h0, 4'h0, 16'h000F, 4'h1);
		expect_exec(OP_QUES_ENAB, 1'h0, 4'h0, 16'h0010, 4'h1);
		check(oper_enable, 16'h000F);
		check(ques_enable, 16'h0010);
		msg("stat:oper:enab?\n", 0);
		expect_exec(OP_OPER_ENAB, 1'h1, 4'h0, 16'h0000, 4'h0);
		check(oper_enable, 16'h000F);
		$display("test enables done");
	endtask

	task automatic t_errors;
		msg(":FOO 1;INIT\n", 0);
		check(got.size(), 0);
		check(syntax_error, 1'h1);
		msg("* CLS\n", 0);
		check(got.size(), 0);
		err_clear <= 1'b1;
		@(posedge core_clk_i);
		err_clear <= 1'b0;
		@(posedge core_clk_i);
		check(syntax_error, 1'h0);
		// A full queue still executes; one instruction more discards the whole message
		msg("INIT;INIT;INIT;abort\n", 0);
		expect_exec(OP_INIT, 1'h0, 4'h0, 16'h0000, 4'h0);
		expect_exec(OP_INIT, 1'h0, 4'h0, 16'h0000, 4'h0);
		expect_exec(OP_INIT, 1'h0, 4'h0, 16'h0000, 4'h0);
		expect_exec(OP_ABORT, 1'h0, 4'h0, 16'h0000, 4'h0);
		check(syntax_error, 1'h0);
		msg("INIT;INIT;INIT;INIT;INIT\n", 0);
		check(got.size(), 0);
		check(syntax_error, 1'h1);
		$display("test errors done");
	endtask

	// Slow host, then a cleared partial message
	task automatic t_hold;
		host.send(":SCAN:RATE 3", 0, 3);
		repeat (10) @(posedge core_clk_i);
		check(got.size(), 0);
		msg("\n", 0);
		expect_exec(OP_SCAN_RATE, 1'h0, 4'h0, 16'h0003, 4'h1);
		host.send("INIT", 0, 0);
		dev_clear <= 1'b1;
		@(posedge core_clk_i);
		dev_clear <= 1'b0;
		@(posedge core_clk_i);
		msg("\n", 0);
		check(got.size(), 0);
		$display("test hold done");
	endtask

	task automatic complete_run;
		$display("checks=%0d errors=%0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Tests take under 500 cycles; far beyond that means a hang
	initial
	begin
		#100us;
		err_count++;
		complete_run();
	end

	initial
	begin
		reset_n_i = 1'b0;
		dev_clear = 1'b0;
		err_clear = 1'b0;
		addr_we = 1'b0;
		addr = 5'h00;
		repeat (20) @(posedge core_clk_i);
		reset_n_i <= 1'b1;
		@(posedge core_clk_i);
		t_reset();
		t_headers();
		t_enables();
		t_errors();
		t_hold();
		complete_run();
	end
endmodule
